// ===== core/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
    // ==========================================================
    // Clock
    localparam int CLK_PERIOD_NS = 40;

    // ==========================================================
    // Link timing limits
    localparam int T_CF2CD_MAX_NS = 600;
    localparam int T_CF2ST0_MAX_NS = 600;
    localparam int T_CFG_MIN_NS = 2000;
    localparam int T_STATUS_MIN_US = 268;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int T_CF2ST1_MAX_US = 1506;
    localparam int T_CF2CK_MIN_US = 1506;
    localparam int T_ST2CK_MIN_NS = 2000;
    localparam int T_CD2UM_MIN_US = 175;
    localparam int T_CD2UM_MAX_US = 437;
    localparam int F_CONFIG_DATA_CLOCK_NARROW_MAX_MHZ = 125;
    localparam int F_CONFIG_DATA_CLOCK_WIDE_MAX_MHZ = 100;
    localparam int CD2CU_CONFIG_DATA_CLOCK_PERIODS = 4;
    localparam int USR_INIT_CYCLES = 8576;
    localparam int WORDS_PER_EDGE = 1;

    // ==========================================================
    // Derived cycle counts; least times round up, longest down
    localparam int CF2CD_CYC = T_CF2CD_MAX_NS / CLK_PERIOD_NS;
    localparam int CF2ST0_CYC = T_CF2ST0_MAX_NS / CLK_PERIOD_NS;
    localparam int CFG_CYC = (T_CFG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MIN_CYC =
        (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MAX_CYC = T_STATUS_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CF2ST1_CYC = T_CF2ST1_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CF2CK_CYC =
        (T_CF2CK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ST2CK_CYC =
        (T_ST2CK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UM_MIN_CYC =
        (T_CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UM_MAX_CYC = T_CD2UM_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CD2CU_NS = CD2CU_CONFIG_DATA_CLOCK_PERIODS * 1000 / F_CONFIG_DATA_CLOCK_WIDE_MAX_MHZ;
    localparam int CD2CU_CYC = (CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Host clock dividers, half periods in clk cycles
    localparam int CONFIG_DATA_CLOCK_HALF_CYC = 4;
    localparam int USRCLK_HALF_CYC = 2;

    // ==========================================================
    // States
    typedef enum logic [2:0] {
        DS_RESET, DS_WAITST, DS_LOAD, DS_INIT, DS_USER
    } pcs_dev_e;
    typedef enum logic [2:0] {
        HS_IDLE, HS_PULSE, HS_WAITST, HS_SETTLE, HS_LOW, HS_HIGH, HS_DONE
    } pcs_host_e;
endpackage
`default_nettype wire

// ===== core/pcs_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pcs_link_if #(parameter int DW = 32);
    logic configReqN;
    logic configDataClock;
    logic userInitClock;
    logic [DW-1:0] data;
    logic devStatusOe;
    logic hostStatusOe;
    logic statusN;
    logic completeOe;
    logic configComplete;

    // Open-drain wires: any enable pulls low
    assign statusN = !(devStatusOe || hostStatusOe);
    assign configComplete = !completeOe;

    modport dev (
        input configReqN, configDataClock, userInitClock, data, statusN,
        output devStatusOe, completeOe
    );
    modport host (
        output configReqN, configDataClock, userInitClock, data,
        output hostStatusOe,
        input statusN, configComplete
    );
endinterface
`default_nettype wire

// ===== core/pcs_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [W-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
            $error("pcs_fifo depth must be a power of two");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;

    assign outValid = (wrPtr_q != rdPtr_q);
    assign inReady = (wrPtr_q != {~rdPtr_q[AW], rdPtr_q[AW-1:0]});
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (inValid && inReady) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
        if (!nrst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (inValid && inReady) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (outValid && outReady) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule // pcs_fifo
`default_nettype wire

// ===== core/pcs_device.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_device #(
    parameter int DW = 32,
    parameter int NWORDS = 1024,
    parameter int STATUS_MIN = pcs_pkg::STATUS_MIN_CYC,
    parameter int INIT_OSC = pcs_pkg::UM_MIN_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    pcs_link_if.dev link,
    input wire logic useUserInitClock,
    output logic [DW-1:0] cfgWord,
    output logic cfgWordValid,
    output logic loading,
    output logic userMode
);
    // ==========================================================
    // Elaboration checks
    generate
        if ((DW != 8 && DW != 16 && DW != 32) || NWORDS < 1 ||
            STATUS_MIN < 1 || STATUS_MIN > 65535 || INIT_OSC < 1 ||
            INIT_OSC > 65535 ||
            STATUS_MIN > pcs_pkg::STATUS_MAX_CYC) begin : g_chk
            $error("pcs_device parameters out of range");
        end
    endgenerate

    // No decompression or security here, so plain limits hold
    localparam logic [15:0] ST_MIN_M1 = 16'(STATUS_MIN - 1);
    localparam logic [15:0] OSC_M1 = 16'(INIT_OSC - 1);
    localparam logic [15:0] CU_CYC = 16'(pcs_pkg::CD2CU_CYC);
    localparam logic [15:0] USR_M1 = 16'(pcs_pkg::USR_INIT_CYCLES - 1);
    localparam logic [31:0] LAST_WORD = 32'(NWORDS - 1);

    // ==========================================================
    // State
    typedef struct packed {
        pcs_pkg::pcs_dev_e st;
        logic [15:0] cnt;
        logic [15:0] ucnt;
        logic [31:0] words;
        logic [1:0] reqS;
        logic [1:0] stS;
        logic [2:0] dclkS;
        logic [2:0] usrS;
        logic [DW-1:0] d1;
        logic [DW-1:0] d2;
        logic [DW-1:0] word;
        logic wordV;
    } pcs_dev_s;

    pcs_dev_s q;
    pcs_dev_s n;
    logic dclkRise;
    logic usrRise;

    // Data passes the same two stages as the clock, so it is aligned
    assign dclkRise = q.dclkS[1] && !q.dclkS[2];
    assign usrRise = q.usrS[1] && !q.usrS[2];

    always_comb begin
        n = q;
        n.reqS = {q.reqS[0], link.configReqN};
        n.stS = {q.stS[0], link.statusN};
        n.dclkS = {q.dclkS[1:0], link.configDataClock};
        n.usrS = {q.usrS[1:0], link.userInitClock};
        n.d1 = link.data;
        n.d2 = q.d1;
        n.wordV = 1'b0;
        case (q.st)
            pcs_pkg::DS_RESET: begin
                if (q.cnt != 16'hffff) begin
                    n.cnt = q.cnt + 16'h1;
                end
                // Released on least time once request is high
                if (q.reqS[1] && q.cnt >= ST_MIN_M1) begin
                    n.st = pcs_pkg::DS_WAITST;
                end
            end
            pcs_pkg::DS_WAITST: begin
                // External party may still hold status low
                if (q.stS[1]) begin
                    n.st = pcs_pkg::DS_LOAD;
                    n.words = '0;
                end
            end
            pcs_pkg::DS_LOAD: begin
                if (dclkRise) begin
                    n.word = q.d2;
                    n.wordV = 1'b1;
                    n.words = q.words + 32'h1;
                    if (q.words == LAST_WORD) begin
                        n.st = pcs_pkg::DS_INIT;
                        n.cnt = '0;
                        n.ucnt = '0;
                    end
                end
            end
            pcs_pkg::DS_INIT: begin
                if (!useUserInitClock) begin
                    n.cnt = q.cnt + 16'h1;
                    if (q.cnt >= OSC_M1) begin
                        n.st = pcs_pkg::DS_USER;
                    end
                end else if (q.cnt < CU_CYC) begin
                    n.cnt = q.cnt + 16'h1;
                end else if (usrRise) begin
                    n.ucnt = q.ucnt + 16'h1;
                    if (q.ucnt == USR_M1) begin
                        n.st = pcs_pkg::DS_USER;
                    end
                end
            end
            pcs_pkg::DS_USER: begin
            end
            default: begin
                n.st = pcs_pkg::DS_RESET;
            end
        endcase
        // Request low restarts from any state
        if (!q.reqS[1]) begin
            n.st = pcs_pkg::DS_RESET;
            if (q.st != pcs_pkg::DS_RESET) begin
                n.cnt = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '{st: pcs_pkg::DS_RESET, default: '0};
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Outputs; three clk after request low, well inside 15
    assign link.devStatusOe = (q.st == pcs_pkg::DS_RESET);
    assign link.completeOe = (q.st == pcs_pkg::DS_RESET) ||
        (q.st == pcs_pkg::DS_WAITST) ||
        (q.st == pcs_pkg::DS_LOAD);
    assign cfgWord = q.word;
    assign cfgWordValid = q.wordV;
    assign loading = (q.st == pcs_pkg::DS_LOAD);
    assign userMode = (q.st == pcs_pkg::DS_USER);
endmodule // pcs_device
`default_nettype wire

// ===== core/pcs_host.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_host #(
    parameter int DW = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    pcs_link_if.host link,
    input wire logic start,
    input wire logic holdStatus,
    input wire logic [DW-1:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    output logic busy,
    output logic done,
    output logic error
);
    // ==========================================================
    // Elaboration checks; 25 MHz clk keeps the data clock far
    // below its 100 MHz ceiling for any width
    generate
        if (DW != 8 && DW != 16 && DW != 32) begin : g_chk
            $error("pcs_host width must be 8, 16 or 32");
        end
    endgenerate

    localparam logic [15:0] CFG_M1 = 16'(pcs_pkg::CFG_CYC - 1);
    localparam logic [15:0] ST2CK_M1 = 16'(pcs_pkg::ST2CK_CYC - 1);
    localparam logic [15:0] HALF_M1 = 16'(pcs_pkg::CONFIG_DATA_CLOCK_HALF_CYC - 1);
    localparam logic [1:0] UHALF_M1 = 2'(pcs_pkg::USRCLK_HALF_CYC - 1);

    typedef struct packed {
        pcs_pkg::pcs_host_e st;
        logic [15:0] cnt;
        logic [1:0] ucnt;
        logic usrClk;
        logic reqN;
        logic config_data_clock;
        logic loaded;
        logic [DW-1:0] data;
        logic [1:0] stS;
        logic [1:0] cdS;
        logic done;
        logic error;
    } pcs_host_s;

    pcs_host_s q;
    pcs_host_s n;
    logic [DW-1:0] fifoData;
    logic fifoValid;
    logic pop;

    // ==========================================================
    // Word buffer; empty buffer stalls the data clock
    pcs_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .inData(wrData),
        .inValid(wrValid),
        .inReady(wrReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(pop)
    );

    // No pop in the cycle that aborts, or the word would be lost
    assign pop = (q.st == pcs_pkg::HS_LOW) && !q.loaded && fifoValid &&
        q.cdS[1] == 1'b0 && q.stS[1];

    always_comb begin
        n = q;
        n.stS = {q.stS[0], link.statusN};
        n.cdS = {q.cdS[0], link.configComplete};
        // Free-running init clock, kept going throughout
        n.ucnt = q.ucnt + 2'h1;
        if (q.ucnt == UHALF_M1) begin
            n.ucnt = '0;
            n.usrClk = !q.usrClk;
        end
        case (q.st)
            pcs_pkg::HS_IDLE: begin
                if (start) begin
                    n.st = pcs_pkg::HS_PULSE;
                    n.reqN = 1'b0;
                    n.cnt = '0;
                    n.done = 1'b0;
                    n.error = 1'b0;
                end
            end
            pcs_pkg::HS_PULSE: begin
                n.cnt = q.cnt + 16'h1;
                if (q.cnt >= CFG_M1) begin
                    n.st = pcs_pkg::HS_WAITST;
                    n.reqN = 1'b1;
                end
            end
            pcs_pkg::HS_WAITST: begin
                // Status is watched, so the short wait applies
                if (q.stS[1]) begin
                    n.st = pcs_pkg::HS_SETTLE;
                    n.cnt = '0;
                end
            end
            pcs_pkg::HS_SETTLE: begin
                n.cnt = q.cnt + 16'h1;
                if (q.cnt >= ST2CK_M1) begin
                    n.st = pcs_pkg::HS_LOW;
                    n.cnt = '0;
                end
            end
            pcs_pkg::HS_LOW: begin
                if (q.cdS[1]) begin
                    n.st = pcs_pkg::HS_DONE;
                    n.done = 1'b1;
                end else if (pop) begin
                    n.data = fifoData;
                    n.loaded = 1'b1;
                    n.cnt = '0;
                end else if (q.loaded) begin
                    n.cnt = q.cnt + 16'h1;
                    if (q.cnt >= HALF_M1) begin
                        n.st = pcs_pkg::HS_HIGH;
                        n.config_data_clock = 1'b1;
                        n.loaded = 1'b0;
                        n.cnt = '0;
                    end
                end
            end
            pcs_pkg::HS_HIGH: begin
                n.cnt = q.cnt + 16'h1;
                if (q.cnt >= HALF_M1) begin
                    n.st = pcs_pkg::HS_LOW;
                    n.config_data_clock = 1'b0;
                    n.cnt = '0;
                end
            end
            pcs_pkg::HS_DONE: begin
                if (start) begin
                    n.st = pcs_pkg::HS_PULSE;
                    n.reqN = 1'b0;
                    n.cnt = '0;
                    n.done = 1'b0;
                end
            end
            default: begin
                n.st = pcs_pkg::HS_IDLE;
            end
        endcase
        // Device fault during load aborts the transfer
        if ((q.st == pcs_pkg::HS_LOW || q.st == pcs_pkg::HS_HIGH) &&
            !q.stS[1]) begin
            n.st = pcs_pkg::HS_IDLE;
            n.config_data_clock = 1'b0;
            n.loaded = 1'b0;
            n.error = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '{st: pcs_pkg::HS_IDLE, reqN: 1'b1, stS: 2'h3,
                default: '0};
        end else begin
            q <= n;
        end
    end

    assign link.configReqN = q.reqN;
    assign link.configDataClock = q.config_data_clock;
    assign link.userInitClock = q.usrClk;
    assign link.data = q.data;
    assign link.hostStatusOe = holdStatus;
    assign busy = (q.st != pcs_pkg::HS_IDLE) && (q.st != pcs_pkg::HS_DONE);
    assign done = q.done;
    assign error = q.error;
endmodule // pcs_host
`default_nettype wire

// ===== tb/pcs_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pcs_link_assertions #(
    parameter int DW = 32,
    parameter int NWORDS = 1024,
    parameter int STATUS_MIN = pcs_pkg::STATUS_MIN_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic configReqN,
    input wire logic configDataClock,
    input wire logic userInitClock,
    input wire logic [DW-1:0] data,
    input wire logic devStatusOe,
    input wire logic hostStatusOe,
    input wire logic statusN,
    input wire logic completeOe,
    input wire logic configComplete
);
    localparam int CFG = pcs_pkg::CFG_CYC;
    localparam int ST2CK = pcs_pkg::ST2CK_CYC;
    localparam int RELMAX = pcs_pkg::CF2ST1_CYC;
    // =====================================
    // Duration counters
    typedef struct packed {
        logic [15:0] reqLow;
        logic [15:0] stLow;
        logic [15:0] stHigh;
        logic [15:0] relWait;
        logic [15:0] words;
        logic config_data_clock;
        logic [3:0] age;
    } pcs_chk_s;
    pcs_chk_s chk_q;
    pcs_chk_s chk_d;
    always_comb begin
        chk_d = chk_q;
        chk_d.reqLow = configReqN ? '0 : chk_q.reqLow + 16'h1;
        chk_d.stLow = statusN ? '0 : chk_q.stLow + 16'h1;
        chk_d.stHigh = !statusN ? '0 : chk_q.stHigh + 16'h1;
        // Outside holds are exempt from the release limit
        chk_d.relWait = (configReqN && !statusN && !hostStatusOe)
            ? chk_q.relWait + 16'h1 : '0;
        chk_d.words = configComplete ? '0
            : chk_q.words + 16'(configDataClock && !chk_q.config_data_clock);
        chk_d.config_data_clock = configDataClock;
        chk_d.age = (chk_q.age == 4'hf) ? chk_q.age : chk_q.age + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (!nrst) chk_q <= '0;
        else chk_q <= chk_d;
    end
    // =====================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence sReqFell;
        $fell(configReqN);
    endsequence
    sequence sDoneLow;
        ##[1:15] (completeOe && !configComplete);
    endsequence
    sequence sStatusLow;
        ##[1:15] (devStatusOe && !statusN);
    endsequence
    a_complete_drops: assert property (sReqFell |-> sDoneLow)
        else $error("complete not pulled low");
    a_status_drops: assert property (sReqFell |-> sStatusLow)
        else $error("status not pulled low");
    a_request_width: assert property (
        $rose(configReqN) |-> chk_q.reqLow >= 16'(CFG))
        else $error("request pulse too short");
    a_status_min: assert property (
        $rose(statusN) |-> chk_q.stLow >= 16'(STATUS_MIN))
        else $error("status low too short");
    a_status_release: assert property (chk_q.relWait <= 16'(RELMAX))
        else $error("status release late");
    a_clock_after_status: assert property (
        $rose(configDataClock) |-> chk_q.stHigh >= 16'(ST2CK))
        else $error("data clock too soon");
    a_word_stable: assert property (configDataClock |-> $stable(data))
        else $error("data moved while clock high");
    a_user_clock_runs: assert property (
        (chk_q.age == 4'hf) && $stable(userInitClock)
        |=> $changed(userInitClock))
        else $error("init clock stalled");
    a_word_count: assert property (
        $rose(configComplete) |-> chk_q.words == 16'(NWORDS))
        else $error("complete after wrong word count");
    a_host_stops: assert property (
        $rose(configDataClock) |-> !configComplete)
        else $error("clocking after complete");
endmodule // pcs_link_assertions
`default_nettype wire

// ===== tb/parallel_passive_config_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module parallel_passive_config_sequencer_bench;
    // Short counts keep the run small
    localparam int NW = 8;
    localparam int SMIN = 20;
    localparam int IOSC = 30;
    localparam int UCYC = pcs_pkg::USR_INIT_CYCLES * 4;
    typedef struct packed {
        logic [31:0] data;
        logic ready;
    } pcs_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic holdStatus = 1'b0;
    logic useUserInit = 1'b0;
    logic [31:0] wrData = '0;
    logic wrValid = 1'b0;
    logic wrReady, hostBusy, hostDone, hostErr;
    logic [31:0] cfgWord;
    logic cfgWordValid, loading, userMode;
    pcs_row_s rows [17];
    logic [31:0] got [$];
    int errTotal = 0;
    int cmpCount = 0;
    int cyc = 0;
    int n;
    initial begin
        forever #20 clk = ~clk;
    end
    // =====================================
    // Both ends on one link
    pcs_link_if #(.DW(32)) link ();
    pcs_device #(.DW(32), .NWORDS(NW), .STATUS_MIN(SMIN), .INIT_OSC(IOSC))
        pcs_device_i (.clk(clk), .nrst(nrst), .link(link),
        .useUserInitClock(useUserInit), .cfgWord(cfgWord),
        .cfgWordValid(cfgWordValid), .loading(loading), .userMode(userMode));
    pcs_host #(.DW(32), .DEPTH(16)) pcs_host_i (.clk(clk), .nrst(nrst),
        .link(link), .start(start), .holdStatus(holdStatus),
        .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
        .busy(hostBusy), .done(hostDone), .error(hostErr));
    pcs_link_assertions #(.DW(32), .NWORDS(NW), .STATUS_MIN(SMIN))
        pcs_link_assertions_i (.clk(clk), .nrst(nrst),
        .configReqN(link.configReqN), .configDataClock(link.configDataClock),
        .userInitClock(link.userInitClock), .data(link.data),
        .devStatusOe(link.devStatusOe), .hostStatusOe(link.hostStatusOe),
        .statusN(link.statusN), .completeOe(link.completeOe),
        .configComplete(link.configComplete));
    // =====================================
    // Helpers
    task automatic wrapUp();
        $display("comparisons %0d errors %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (nrst && cfgWordValid === 1'b1) got.push_back(cfgWord);
        cyc <= cyc + 1;
        if (cyc == 45000) begin
            errTotal++;
            wrapUp();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return link.statusN;
            1: return link.configComplete;
            2: return userMode;
            3: return hostErr;
            4: return loading;
            5: return link.configReqN;
            default: return link.configDataClock;
        endcase
    endfunction
    // #1 lets the edge's updates land before sampling
    task automatic waitFor(input int s, input logic lvl, input int lim,
            output int cnt);
        cnt = 0;
        while (pick(s) !== lvl && cnt < lim) begin
            @(posedge clk);
            #1 cnt++;
        end
        if (cnt >= lim) begin
            errTotal++;
            $display("ERROR %0t: wait %0d timed out", $time, s);
        end
    endtask
    task automatic pushRow(input int i);
        @(posedge clk);
        wrData <= rows[i].data;
        wrValid <= 1'b1;
        #1 check(32'(wrReady), 32'(rows[i].ready));
    endtask
    task automatic kick();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    // =====================================
    // Sequence
    initial begin
        for (int i = 0; i < 17; i++) begin
            rows[i] = '{{8'(i), 8'(~i), 8'(i * 3), 8'(i ^ 8'h5a)}, i < 16};
        end
        repeat (3) @(posedge clk);
        #1 check(32'({link.configReqN, link.configDataClock}), 32'h2);
        @(posedge clk);
        nrst <= 1'b1;
        waitFor(0, 1'b1, SMIN + 10, n);
        check(32'(n >= SMIN - 1 && n <= SMIN + 6), 32'h1);
        check(32'({link.configComplete, userMode, hostErr}), 32'h0);
        // Last row finds the buffer full and is refused
        for (int i = 0; i < 17; i++) begin
            pushRow(i);
        end
        @(posedge clk);
        wrValid <= 1'b0;
        kick();
        waitFor(5, 1'b0, 10, n);
        waitFor(0, 1'b0, 20, n);
        check(32'(n <= 15), 32'h1);
        waitFor(1, 1'b1, 3000, n);
        waitFor(2, 1'b1, IOSC + 10, n);
        check(32'(n >= IOSC - 1 && n <= IOSC + 2), 32'h1);
        check(32'(hostDone), 32'h1);
        for (int k = 0; k < NW; k++) begin
            check(got[k], rows[k].data);
        end
        // Outside hold stretches status past its least time
        @(posedge clk);
        useUserInit <= 1'b1;
        holdStatus <= 1'b1;
        kick();
        waitFor(5, 1'b0, 10, n);
        waitFor(1, 1'b0, 20, n);
        check(32'(n <= 15), 32'h1);
        repeat (200) @(posedge clk);
        #1 check(32'({link.statusN, link.configDataClock, loading}), 32'h0);
        @(posedge clk);
        holdStatus <= 1'b0;
        waitFor(1, 1'b1, 3000, n);
        waitFor(2, 1'b1, UCYC + 100, n);
        check(32'(n >= UCYC - 4 && n <= UCYC + 12), 32'h1);
        check(32'(got.size()), 32'(2 * NW));
        for (int k = NW; k < 2 * NW; k++) begin
            check(got[k], rows[k].data);
        end
        check(32'(wrReady), 32'h1);
        // Status pulled low mid-load aborts the host
        for (int i = 0; i < 4; i++) begin
            pushRow(i);
        end
        @(posedge clk);
        useUserInit <= 1'b0;
        wrValid <= 1'b0;
        kick();
        waitFor(4, 1'b1, 3000, n);
        check(32'(hostBusy), 32'h1);
        // Host only watches for a fault once it clocks words
        waitFor(6, 1'b1, 200, n);
        @(posedge clk);
        holdStatus <= 1'b1;
        waitFor(3, 1'b1, 20, n);
        check(32'({hostErr, link.configComplete}), 32'h2);
        wrapUp();
    end
endmodule // parallel_passive_config_sequencer_bench
`default_nettype wire
